// [common/fifo_read_pkg.sv]
// Constants and types shared by the read-side FIFO design files.
// Assumes one clock for both ports and the register map chosen here.
package fifo_read_pkg;

    // ------------------------------------------------------------
    // Storage geometry
    // ------------------------------------------------------------
    localparam int unsigned WORD_W  = 36;
    localparam int unsigned BYTE_W  = 9;
    localparam int unsigned DEPTH   = 64;
    localparam int unsigned PTR_W   = 6;
    localparam int unsigned CNT_W   = 7;
    localparam logic [6:0]  FULL_COUNT = 7'h40;

    // ------------------------------------------------------------
    // Register bus layout
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam logic [7:0]  OFS_CONFIG = 8'h00;
    localparam logic [7:0]  OFS_STATUS = 8'h04;
    localparam logic [7:0]  OFS_MASK   = 8'h08;
    localparam logic [7:0]  OFS_LEVEL  = 8'h0C;

    // Config fields: almost-empty offset low, almost-full offset high
    localparam int unsigned CFG_AE_LSB = 0;
    localparam int unsigned CFG_AF_LSB = 8;
    localparam logic [5:0]  AE_OFFSET_RESET = 6'h08;
    localparam logic [5:0]  AF_OFFSET_RESET = 6'h08;

    // Status and mask bit positions
    localparam int unsigned EVT_W        = 5;
    localparam int unsigned EVT_EMPTY    = 0;
    localparam int unsigned EVT_FULL     = 1;
    localparam int unsigned EVT_ALM_EMPTY = 2;
    localparam int unsigned EVT_ALM_FULL = 3;
    localparam int unsigned EVT_MAIL     = 4;
    localparam logic [4:0]  MASK_RESET   = 5'h00;

    // Level register fields
    localparam int unsigned LVL_FLAGS_LSB = 8;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SIZE_LONG = 2'b00,
        SIZE_WORD = 2'b01,
        SIZE_BYTE = 2'b10,
        SIZE_MAIL = 2'b11
    } bus_size_t;

    typedef enum logic [1:0] {
        SWAP_NONE      = 2'b00,
        SWAP_BYTES     = 2'b01,
        SWAP_HALVES    = 2'b10,
        SWAP_IN_HALVES = 2'b11
    } swap_mode_t;

    localparam logic [1:0]  PART_RESET = 2'h0;
    localparam logic [1:0]  LAST_WORD_PART = 2'h1;
    localparam logic [1:0]  LAST_BYTE_PART = 2'h3;

endpackage : fifo_read_pkg

// [rtl/fifo_store.sv]
// Dual-port store of long words, one write and one registered read.
// Assumes a single clock; read data follow the address of the edge.
`timescale 1ns/1ps
`default_nettype none
module fifo_store
    import fifo_read_pkg::*;
(
    input  wire logic              clk_in,     // System clock
    input  wire logic              wr_en_in,   // Write strobe
    input  wire logic [PTR_W-1:0]  wr_addr_in, // Write address
    input  wire logic [WORD_W-1:0] wr_data_in, // Write data
    input  wire logic [PTR_W-1:0]  rd_addr_in, // Read address
    output logic      [WORD_W-1:0] rd_data_out // Registered read data
);

    logic [WORD_W-1:0] cells [DEPTH];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // No reset: contents are only read behind the count
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            cells[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rd_data_out <= cells[rd_addr_in];
    end

endmodule // fifo_store
`default_nettype wire

// [rtl/long_word_swap.sv]
// Byte-order rearrangement of one long word of four 9-bit bytes.
// Purely combinational; bits inside each byte keep their order.
`timescale 1ns/1ps
`default_nettype none
module long_word_swap
    import fifo_read_pkg::*;
(
    input  wire swap_mode_t        mode_in,  // Swap order
    input  wire logic [WORD_W-1:0] word_in,  // Word as stored
    output logic      [WORD_W-1:0] word_out  // Word rearranged
);

    logic [BYTE_W-1:0] b3;
    logic [BYTE_W-1:0] b2;
    logic [BYTE_W-1:0] b1;
    logic [BYTE_W-1:0] b0;

    assign {b3, b2, b1, b0} = word_in;

    always_comb begin
        unique case (mode_in)
            SWAP_NONE:      word_out = {b3, b2, b1, b0};
            SWAP_BYTES:     word_out = {b0, b1, b2, b3};
            SWAP_HALVES:    word_out = {b1, b0, b3, b2};
            SWAP_IN_HALVES: word_out = {b2, b3, b0, b1};
        endcase
    end

endmodule // long_word_swap
`default_nettype wire

// [rtl/fifo_read_port.sv]
// Read side of a 64 x 36 FIFO with bus sizing, swapping and mailbox.
// Assumes write and read ports share clk_in; pins are synchronous.
//
// Notes on behaviour
// - Swap select reorders the four bytes: none, reverse, halves, in-halves.
// - Word size gives two reads; big-endian upper half first, little lower.
// - Byte size gives four reads; big from top byte, little from bottom.
// - Both size selects high read the mailbox on all 36 bits.
// - Empty flag released in the second cycle after a write into empty.
// - Narrow reads assert empty only on the last part of the word.
// - Full flag released after the read of the last part.
// - Almost-empty released the next cycle; reference is the last part.
// - Almost-full released the next cycle; reference is the last part.
// - Swap order sampled on the first part, kept for the whole word.
// - Bytes are reordered first, then split into words or bytes.
// - Mailbox data is never swapped; bits inside bytes keep order.
`timescale 1ns/1ps
`default_nettype none
module fifo_read_port
    import fifo_read_pkg::*;
(
    input  wire logic              clk_in,              // 100 MHz clock
    input  wire logic              reset_in,            // Async reset
    // Write port
    input  wire logic              write_enable_in,     // FIFO write
    input  wire logic              mail_write_in,       // Mailbox write
    input  wire logic [WORD_W-1:0] write_data_in,       // Write data
    // Read port
    input  wire logic              read_port_select_n_in, // Chip select
    input  wire logic              read_port_direction_in, // High = write
    input  wire logic              read_enable_in,      // Read enable
    input  wire logic              bus_size_select_lsb_in, // Size bit 0
    input  wire logic              bus_size_select_msb_in, // Size bit 1
    input  wire logic              endian_select_n_in,  // Low = big
    input  wire logic              swap_select_lsb_in,  // Swap bit 0
    input  wire logic              swap_select_msb_in,  // Swap bit 1
    output logic      [WORD_W-1:0] read_data_out,       // Read bus
    // Flags
    output logic                   empty_flag_n_out,    // Low = empty
    output logic                   full_flag_n_out,     // Low = full
    output logic                   almost_empty_flag_n_out, // Low = few
    output logic                   almost_full_flag_n_out,  // Low = many
    output logic                   mail_flag_n_out,     // Low = new mail
    // Register bus
    input  wire logic [ADDR_W-1:0] reg_addr_in,         // Byte address
    input  wire logic [DATA_W-1:0] reg_wdata_in,        // Write data
    input  wire logic              reg_write_in,        // Write strobe
    input  wire logic              reg_read_in,         // Read strobe
    output logic      [DATA_W-1:0] reg_rdata_out,       // Read data
    output logic                   irq_out              // Interrupt
);

    // ----
    // Declarations
    // ----
    logic [PTR_W-1:0]  wr_ptr;
    logic [PTR_W-1:0]  rd_ptr;
    logic [PTR_W-1:0]  next_rd_ptr;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  next_count;
    logic [WORD_W-1:0] head_word;
    logic [WORD_W-1:0] swapped_head;
    logic [WORD_W-1:0] held_word;
    logic [WORD_W-1:0] cur_word;
    logic [WORD_W-1:0] part_data;
    logic [WORD_W-1:0] mailbox;
    logic [1:0]        part;
    bus_size_t         held_size;
    bus_size_t         cur_size;
    bus_size_t         pin_size;
    logic              held_little;
    logic              cur_little;
    logic              access;
    logic              fifo_read;
    logic              mail_read;
    logic              last_part;
    logic              take_word;
    logic              fifo_write;
    logic [5:0]        ae_offset;
    logic [5:0]        af_offset;
    logic [EVT_W-1:0]  status;
    logic [EVT_W-1:0]  mask;
    logic [EVT_W-1:0]  events;
    logic              status_clear;
    logic              next_almost_empty;
    logic              next_almost_full;

    // ----
    // Port decode
    // ----
    assign pin_size = bus_size_t'({bus_size_select_msb_in,
                                   bus_size_select_lsb_in});
    assign access = !read_port_select_n_in && !read_port_direction_in
                    && read_enable_in;
    // A FIFO read is refused while empty; the reader sees no change
    assign fifo_read = access && (pin_size != SIZE_MAIL)
                       && empty_flag_n_out;
    assign mail_read = access && (pin_size == SIZE_MAIL);
    assign fifo_write = write_enable_in && (count != FULL_COUNT);

    // ----
    // Storage and swap
    // ----
    // Read address looks one edge ahead so back-to-back reads see
    // the next word without a bubble, unless that word was written on the same edge as the read before.
    assign next_rd_ptr = (fifo_read && last_part) ? rd_ptr + 6'h01
                                                  : rd_ptr;

    fifo_store u_store (
        .clk_in      (clk_in),
        .wr_en_in    (fifo_write),
        .wr_addr_in  (wr_ptr),
        .wr_data_in  (write_data_in),
        .rd_addr_in  (next_rd_ptr),
        .rd_data_out (head_word)
    );

    long_word_swap u_swap (
        .mode_in  (swap_mode_t'({swap_select_msb_in,
                                 swap_select_lsb_in})),
        .word_in  (head_word),
        .word_out (swapped_head)
    );

    // ----
    // Long-word sequencing
    // ----
    // Size, endian and swap are caught on the first part only
    assign take_word = (part == PART_RESET);
    assign cur_word = take_word ? swapped_head : held_word;
    assign cur_size = take_word ? pin_size : held_size;
    assign cur_little = take_word ? endian_select_n_in : held_little;

    always_comb begin
        unique case (cur_size)
            SIZE_WORD: last_part = (part == LAST_WORD_PART);
            SIZE_BYTE: last_part = (part == LAST_BYTE_PART);
            default:   last_part = 1'b1;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            part        <= PART_RESET;
            held_word   <= '0;
            held_size   <= SIZE_LONG;
            held_little <= 1'b0;
        end else if (fifo_read) begin
            // A mailbox read in between leaves this state alone
            if (take_word) begin
                held_word   <= swapped_head;
                held_size   <= pin_size;
                held_little <= endian_select_n_in;
            end
            part <= last_part ? PART_RESET : part + 2'h1;
        end
    end

    // ----
    // Part selection onto the bus
    // ----
    // Unused lanes drive zero; the reader must not rely on them
    always_comb begin
        part_data = '0;
        unique case (cur_size)
            SIZE_WORD: begin
                if (cur_little) begin
                    part_data[17:0] = part[0] ? cur_word[35:18]
                                              : cur_word[17:0];
                end else begin
                    part_data[35:18] = part[0] ? cur_word[17:0]
                                               : cur_word[35:18];
                end
            end
            SIZE_BYTE: begin
                if (cur_little) begin
                    part_data[8:0] = 9'(cur_word >> (9 * part));
                end else begin
                    part_data[35:27] = 9'(cur_word << (9 * part)
                                          >> 27);
                end
            end
            default: part_data = cur_word;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            read_data_out <= '0;
        end else if (mail_read) begin
            read_data_out <= mailbox;
        end else if (fifo_read) begin
            read_data_out <= part_data;
        end
    end

    // ----
    // Pointers and count
    // ----
    always_comb begin
        next_count = count;
        if (fifo_write) begin
            next_count = next_count + 7'h01;
        end
        if (fifo_read && last_part) begin
            next_count = next_count - 7'h01;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (fifo_write) begin
                wr_ptr <= wr_ptr + 6'h01;
            end
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // ----
    // Flags
    // ----
    assign next_almost_empty = (next_count <= {1'b0, ae_offset});
    assign next_almost_full = (next_count >= FULL_COUNT - {1'b0, af_offset});

    // Empty falls at once on the last read but rises one edge late:
    // the store needs that edge to present a word just written.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            empty_flag_n_out        <= 1'b0;
            full_flag_n_out         <= 1'b1;
            almost_empty_flag_n_out <= 1'b0;
            almost_full_flag_n_out  <= 1'b1;
        end else begin
            empty_flag_n_out <= (next_count != '0) && (count != '0);
            full_flag_n_out  <= (next_count != FULL_COUNT);
            almost_empty_flag_n_out <= !next_almost_empty;
            almost_full_flag_n_out  <= !next_almost_full;
        end
    end

    // ----
    // Mailbox
    // ----
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mailbox         <= '0;
            mail_flag_n_out <= 1'b1;
        end else begin
            if (mail_write_in) begin
                mailbox <= write_data_in;
            end
            // New mail wins over a read in the same cycle
            if (mail_write_in) begin
                mail_flag_n_out <= 1'b0;
            end else if (mail_read) begin
                mail_flag_n_out <= 1'b1;
            end
        end
    end

    // ----
    // Events and interrupt
    // ----
    assign events[EVT_EMPTY]     = empty_flag_n_out && (next_count == '0);
    assign events[EVT_FULL]      = full_flag_n_out
                                   && (next_count == FULL_COUNT);
    assign events[EVT_ALM_EMPTY] = almost_empty_flag_n_out
                                   && next_almost_empty;
    assign events[EVT_ALM_FULL]  = almost_full_flag_n_out
                                   && next_almost_full;
    assign events[EVT_MAIL]      = mail_write_in;

    assign status_clear = reg_read_in && (reg_addr_in == OFS_STATUS);

    // Set wins over the clearing read so no event is lost
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            status <= '0;
        end else begin
            status <= (status_clear ? '0 : status) | events;
        end
    end

    assign irq_out = |(status & mask);

    // ----
    // Register bus
    // ----
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ae_offset <= AE_OFFSET_RESET;
            af_offset <= AF_OFFSET_RESET;
            mask      <= MASK_RESET;
        end else if (reg_write_in) begin
            if (reg_addr_in == OFS_CONFIG) begin
                ae_offset <= reg_wdata_in[CFG_AE_LSB +: 6];
                af_offset <= reg_wdata_in[CFG_AF_LSB +: 6];
            end
            if (reg_addr_in == OFS_MASK) begin
                mask <= reg_wdata_in[EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= '0;
            if (reg_read_in) begin
                unique case (reg_addr_in)
                    OFS_CONFIG: begin
                        reg_rdata_out[CFG_AE_LSB +: 6] <= ae_offset;
                        reg_rdata_out[CFG_AF_LSB +: 6] <= af_offset;
                    end
                    OFS_STATUS: reg_rdata_out[EVT_W-1:0] <= status;
                    OFS_MASK:   reg_rdata_out[EVT_W-1:0] <= mask;
                    OFS_LEVEL: begin
                        reg_rdata_out[CNT_W-1:0] <= count;
                        reg_rdata_out[LVL_FLAGS_LSB +: 4] <=
                            {almost_full_flag_n_out,
                             almost_empty_flag_n_out,
                             full_flag_n_out, empty_flag_n_out};
                    end
                    default: reg_rdata_out <= '0;
                endcase
            end
        end
    end

endmodule // fifo_read_port
`default_nettype wire

// [tb/long_word_source.sv]
// Write-side producer model for the FIFO read-port bench.
// Assumes the single clk_in shared with the design.
`timescale 1ns/1ps
`default_nettype none
module long_word_source
    import fifo_read_pkg::*;
(
    input  wire logic              clk_in,           // System clock
    output logic                   write_enable_out, // FIFO write
    output logic                   mail_write_out,   // Mailbox write
    output logic      [WORD_W-1:0] write_data_out    // Write data
);
    initial begin
        write_enable_out = 1'b0;
        mail_write_out   = 1'b0;
        write_data_out   = '0;
    end

    // Released data turn to the inverse so stale values never match
    // mb high sends the word to the mailbox instead of the FIFO
    task automatic put(input logic [WORD_W-1:0] d, input logic mb = 1'b0);
        @(posedge clk_in);
        write_enable_out <= !mb;
        mail_write_out   <= mb;
        write_data_out   <= d;
        @(posedge clk_in);
        write_enable_out <= 1'b0;
        mail_write_out   <= 1'b0;
        write_data_out   <= ~d;
    endtask
endmodule // long_word_source
`default_nettype wire

// [tb/fifo_read_port_assertions.sv]
// Port-level checker for the FIFO read port, attached by bind.
// Assumes one clock domain and the offsets at their reset values.
`timescale 1ns/1ps
`default_nettype none
module fifo_read_port_assertions
    import fifo_read_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire logic              write_enable_in,
    input  wire logic              mail_write_in,
    input  wire logic [WORD_W-1:0] write_data_in,
    input  wire logic              read_port_select_n_in,
    input  wire logic              read_port_direction_in,
    input  wire logic              read_enable_in,
    input  wire logic              bus_size_select_lsb_in,
    input  wire logic              bus_size_select_msb_in,
    input  wire logic [WORD_W-1:0] read_data_out,
    input  wire logic              empty_flag_n_out,
    input  wire logic              full_flag_n_out,
    input  wire logic              almost_empty_flag_n_out,
    input  wire logic              almost_full_flag_n_out,
    input  wire logic              mail_flag_n_out,
    input  wire logic              reg_read_in,
    input  wire logic [DATA_W-1:0] reg_rdata_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    logic              rd_req;
    logic              mail_rd;
    logic [WORD_W-1:0] mail_copy;
    assign rd_req  = !read_port_select_n_in && !read_port_direction_in
                     && read_enable_in;
    assign mail_rd = rd_req && bus_size_select_lsb_in
                     && bus_size_select_msb_in;

    // Mailbox shadow
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mail_copy <= '0;
        end else if (mail_write_in) begin
            mail_copy <= write_data_in;
        end
    end

    // Only a write into a truly empty store; no write in the cycle before it
    empty_release_a: assert property (
        write_enable_in && !empty_flag_n_out && !$past(write_enable_in)
        |-> ##1 !empty_flag_n_out ##1 empty_flag_n_out)
        else $error("empty release timing");
    rdata_idle_a: assert property (
        !reg_read_in |=> reg_rdata_out == '0)
        else $error("idle read data");
    deselect_hold_a: assert property (
        !rd_req |=> $stable(read_data_out))
        else $error("bus moved unread");
    refused_read_a: assert property (
        rd_req && !mail_rd && !empty_flag_n_out |=> $stable(read_data_out))
        else $error("bus moved while empty");
    mail_read_a: assert property (
        mail_rd |=> read_data_out == $past(mail_copy))
        else $error("mailbox data");
    mail_flag_a: assert property (
        mail_write_in |=> !mail_flag_n_out)
        else $error("mail flag not set");
    empty_almost_a: assert property (
        !empty_flag_n_out |-> !almost_empty_flag_n_out)
        else $error("empty not almost");
    full_almost_a: assert property (
        !full_flag_n_out |-> !almost_full_flag_n_out)
        else $error("full not almost");

    cover property (mail_rd);
    cover property (!full_flag_n_out);
    cover property (rd_req && bus_size_select_msb_in
                    && !bus_size_select_lsb_in);
endmodule // fifo_read_port_assertions

bind fifo_read_port fifo_read_port_assertions i_chk (.*);
`default_nettype wire

// [tb/tb_fifo_read_port.sv]
// Self-checking bench for the FIFO read port, one task per scenario.
// Assumes the producer model on the write port and one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_fifo_read_port
    import fifo_read_pkg::*;
;
    logic clk_in = 0, reset_in = 1, read_port_select_n_in = 1;
    logic read_port_direction_in = 0, read_enable_in = 0;
    logic bus_size_select_lsb_in = 0, bus_size_select_msb_in = 0;
    logic endian_select_n_in = 0, swap_select_lsb_in = 0;
    logic swap_select_msb_in = 0, reg_write_in = 0, reg_read_in = 0;
    logic write_enable_in, mail_write_in, empty_flag_n_out, irq_out;
    logic full_flag_n_out, almost_empty_flag_n_out;
    logic almost_full_flag_n_out, mail_flag_n_out;
    logic [WORD_W-1:0] write_data_in, read_data_out;
    logic [ADDR_W-1:0] reg_addr_in = '0;
    logic [DATA_W-1:0] reg_wdata_in = '0, reg_rdata_out;
    int fail_count = 0, check_count = 0;
    localparam logic [35:0] PAT = {9'h1A1, 9'h0B2, 9'h1C3, 9'h0D4};
    localparam logic [35:0] MB = 36'h9_8765_4321;

    always #5 clk_in = ~clk_in;
    fifo_read_port i_dut (.*);
    long_word_source i_src (.clk_in(clk_in),
        .write_enable_out(write_enable_in),
        .mail_write_out(mail_write_in), .write_data_out(write_data_in));

    // ----
    // Helpers
    // ----
    function automatic logic [35:0] swap_of(logic [35:0] d, logic [1:0] m);
        case (m)
            2'h0: swap_of = d;
            2'h1: swap_of = {d[8:0], d[17:9], d[26:18], d[35:27]};
            2'h2: swap_of = {d[17:0], d[35:18]};
            default: swap_of = {d[26:18], d[35:27], d[8:0], d[17:9]};
        endcase
    endfunction
    task automatic chk_d(string n, logic [35:0] e, logic [35:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_r(string n, logic [31:0] e, logic [31:0] g);
        chk_d(n, 36'(e), 36'(g));
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wait_ne;
        for (int i = 0; i < 20 && empty_flag_n_out !== 1'b1; i++) tick(1);
        chk_r("empty_n", 1, empty_flag_n_out);
    endtask
    task automatic rd(logic [1:0] sz, logic e, logic [1:0] m,
                      output logic [35:0] q);
        @(posedge clk_in);
        {read_port_select_n_in, read_enable_in} <= 2'b01;
        {bus_size_select_msb_in, bus_size_select_lsb_in} <= sz;
        endian_select_n_in <= e;
        {swap_select_msb_in, swap_select_lsb_in} <= m;
        @(posedge clk_in);
        {read_port_select_n_in, read_enable_in} <= 2'b10;
        #1 q = read_data_out;
    endtask
    task automatic rw(logic [7:0] a, logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rr(logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        logic [31:0] d;
        rr(OFS_CONFIG, d);
        chk_r("config", 32'h0000_0808, d);
        rr(OFS_MASK, d);
        chk_r("mask", 32'h0, d);
        rw(8'h10, 32'hFFFF_FFFF);
        rr(8'h10, d);
        chk_r("unmapped", 32'h0, d);
        rr(OFS_LEVEL, d);
        chk_r("level", 32'h0000_0A00, d);
    endtask
    task automatic t_long;
        logic [35:0] q, q0;
        for (int m = 0; m < 4; m++) begin
            i_src.put(PAT);
            #1 chk_r("empty_n", 0, empty_flag_n_out);
            tick(1);
            chk_r("empty_n", 1, empty_flag_n_out);
            q0 = read_data_out;
            @(posedge clk_in) read_port_direction_in <= 1'b1;
            rd(2'h0, 1'b0, m[1:0], q);
            chk_d("held", q0, q);
            @(posedge clk_in) read_port_direction_in <= 1'b0;
            rd(2'h0, 1'b0, m[1:0], q);
            chk_d("long", swap_of(PAT, m[1:0]), q);
            tick(2);
        end
    endtask
    task automatic t_narrow;
        logic [35:0] q, s, e, mk;
        int n, w, x;
        for (int k = 0; k < 4; k++) begin
            n = k < 2 ? 2 : 4;
            w = 36 / n;
            mk = (36'h1 << w) - 36'h1;
            s = swap_of(PAT, k[1:0]);
            i_src.put(PAT);
            wait_ne;
            for (int p = 0; p < n; p++) begin
                rd(k < 2 ? 2'h1 : 2'h2, k[0], p == 0 ? k[1:0] : ~k[1:0], q);
                x = k[0] ? p : n - 1 - p;
                e = (s >> (w * x)) & mk;
                q = k[0] ? q & mk : q >> (36 - w);
                chk_d("part", e, q);
                tick(2);
                chk_r("empty_n", p < n - 1, empty_flag_n_out);
            end
        end
    endtask
    task automatic t_mail;
        logic [35:0] q;
        logic [31:0] d;
        rr(OFS_STATUS, d);
        rw(OFS_MASK, 32'h10);
        i_src.put(PAT);
        wait_ne;
        rd(2'h1, 1'b0, 2'h0, q);
        chk_d("upper", PAT >> 18, q >> 18);
        i_src.put(MB, 1'b1);
        tick(1);
        chk_r("mail_n", 0, mail_flag_n_out);
        chk_r("irq", 1, irq_out);
        rd(2'h3, 1'b0, 2'h3, q);
        chk_d("mail", MB, q);
        chk_r("mail_n", 1, mail_flag_n_out);
        rr(OFS_STATUS, d);
        chk_r("status", 32'h0000_0010, d);
        chk_r("irq", 0, irq_out);
        rd(2'h1, 1'b0, 2'h1, q);
        chk_d("lower", PAT & 36'h3FFFF, q >> 18);
        rw(OFS_MASK, 32'h0);
    endtask
    task automatic t_fill;
        logic [35:0] q;
        logic [31:0] d;
        int c;
        for (int i = 0; i < 65; i++) i_src.put(36'h111 * i);
        rr(OFS_LEVEL, d);
        chk_r("level", 32'h0000_0540, d);
        for (int i = 0; i < 64; i++) begin
            rd(2'h0, 1'b0, 2'h0, q);
            chk_d("fifo", 36'h111 * i, q);
            c = 63 - i;
            tick(2);
            chk_r("full_n", 1, full_flag_n_out);
            chk_r("af_n", c < 56, almost_full_flag_n_out);
            chk_r("ae_n", c > 8, almost_empty_flag_n_out);
        end
        chk_r("empty_n", 0, empty_flag_n_out);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        t_regs;
        t_long;
        t_narrow;
        t_mail;
        t_fill;
        results;
    end
    // Run takes about 530 cycles
    initial begin
        #100000;
        fail_count++;
        results;
    end
endmodule // tb_fifo_read_port
`default_nettype wire
